// [hdl/coproc_pkg.sv]
/*
  Constants for the numeric coprocessor port: port decode, AXI4-Lite register map,
  field positions, response codes and timing counts.
  Assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
*/
package coproc_pkg;
  // -------------------------------------------------------------
  // Port decode
  // -------------------------------------------------------------
  localparam logic [15:0] PORT_OPCODE   = 16'h00f8;
  localparam logic [15:0] PORT_OPERAND  = 16'h00fa;
  localparam logic [15:0] PORT_CONTROL  = 16'h00fc;
  localparam logic [15:0] PORT_RESERVED = 16'h00fe;

  // -------------------------------------------------------------
  // Register map (byte addresses)
  // -------------------------------------------------------------
  localparam logic [7:0] REG_CONTROL  = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_EVENTS   = 8'h08;
  localparam logic [7:0] REG_EV_CLEAR = 8'h0c;
  localparam logic [7:0] REG_EV_EN    = 8'h10;
  localparam logic [7:0] REG_OPCODE   = 8'h14;
  localparam logic [7:0] REG_OPERAND  = 8'h18;
  localparam logic [7:0] REG_DONE     = 8'h1c;
  localparam logic [7:0] REG_REQ      = 8'h20;
  localparam logic [7:0] REG_WDATA    = 8'h24;

  // CONTROL fields
  localparam int CTL_CLKMODE = 0;
  // DONE write fields
  localparam int DONE_FINISH = 0;
  localparam int DONE_EXCEPT = 1;
  // STATUS fields
  localparam int ST_BUSY    = 0;
  localparam int ST_ERROR   = 1;
  localparam int ST_REQ     = 2;
  localparam int ST_STRAP   = 3;
  localparam int ST_ARMED   = 4;
  // Event bits
  localparam int EV_WIDTH   = 4;
  localparam int EV_OPCODE  = 0;
  localparam int EV_OPERAND = 1;
  localparam int EV_READ    = 2;
  localparam int EV_ERROR   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // -------------------------------------------------------------
  // Clock modes
  // -------------------------------------------------------------
  localparam logic [1:0] DIV_RATIO     = 2'd3;
  localparam logic [1:0] DIV_LAST      = 2'd2;
endpackage

// [hdl/coproc_port.sv]
/*
  Device end of a numeric coprocessor port, with an AXI4-Lite register file
  through which the execution engine (software model) drives busy, error and
  operand-transfer requests.
  Assumes host glue decodes the four ports 00F8..00FE into selects and command
  bits, drives the strobes from I/O read/write commands, and that all inputs
  are synchronous to clock.
*/
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Respond only to ports 00F8, 00FA and 00FC.
// - Busy asserted while executing an instruction, released on completion.
// - Unmasked exception asserts error before busy goes inactive; here error rises in the same cycle that busy drops.
// - Strap low: run from host clock divided by three.
// - Strap high: run from undivided external clock, independent of host.
// - Accept a separate clock so the parts can be in different domains; here ext_clock_tick is only an enable synchronous to clock.
// - Transfer request held high until the host drives acknowledge low; here a DONE finish write that ends the instruction also drops it.
// - Escape I/O operations complete with zero wait states.
// - After busy drops, no requests until another escape instruction.
module coproc_port (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // External core clock enable, used with the strap high
  input  wire logic        ext_clock_tick,
  input  wire logic        clock_mode_strap,
  // Host side pins
  input  wire logic        select_low_active,
  input  wire logic        select_high_active,
  input  wire logic        command_bit_zero,
  input  wire logic        command_bit_one,
  input  wire logic        coproc_read_strobe,
  input  wire logic        coproc_write_strobe,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe,
  output logic             busy,
  output logic             error,
  output logic             operand_transfer_request,
  input  wire logic        operand_transfer_ack,
  // Core clock enable seen by the engine
  output logic             core_tick,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Interrupt
  output logic             irq
);
  // ---------------------------------------------------------------
  // Port decode and clock mode
  // ---------------------------------------------------------------
  logic       sel;
  logic       wr_op, wr_operand, wr_ctl, rd_any;
  logic       strap, armed;
  logic [1:0] div_cnt, next_div_cnt;
  logic       strap_done;

  // Selects must be active; the reserved fourth port (both command bits) is ignored
  assign sel        = select_high_active && !select_low_active
                      && !(command_bit_zero && command_bit_one);
  assign wr_op      = sel && coproc_write_strobe && !command_bit_zero && !command_bit_one;
  assign wr_operand = sel && coproc_write_strobe && command_bit_zero;
  assign wr_ctl     = sel && coproc_write_strobe && command_bit_one;
  assign rd_any     = sel && coproc_read_strobe;

  always_comb begin
    next_div_cnt = (div_cnt == coproc_pkg::DIV_LAST) ? 2'd0 : div_cnt + 2'd1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_cnt    <= 2'd0;
      strap      <= 1'b0;
      strap_done <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      if (!strap_done) begin
        strap      <= clock_mode_strap; // Strap caught once after reset release
        strap_done <= 1'b1;
      end
    end
  end

  // Divided host clock or the separate external clock
  assign core_tick = strap ? ext_clock_tick : (div_cnt == coproc_pkg::DIV_LAST);

  // ---------------------------------------------------------------
  // Host data path: zero wait state, data held in flops
  // ---------------------------------------------------------------
  logic [15:0] opcode, operand, read_word;
  logic [15:0] next_data_out;

  always_comb begin
    next_data_out = data_out;
    if (rd_any)
      next_data_out = read_word;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_out <= 16'h0000;
      data_oe  <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe  <= rd_any;
    end
  end

  // ---------------------------------------------------------------
  // Execution handshake state
  // ---------------------------------------------------------------
  logic next_busy, next_error, next_req, next_armed;
  logic [15:0] next_opcode, next_operand;
  logic done_wr, done_finish, done_except, req_wr;

  always_comb begin
    next_busy    = busy;
    next_error   = error;
    next_req     = operand_transfer_request;
    next_armed   = armed;
    next_opcode  = opcode;
    next_operand = operand;
    if (wr_op) begin
      next_opcode = data_in;
      next_busy   = 1'b1;
      next_armed  = 1'b1;
      next_error  = 1'b0;
    end
    if (wr_operand)
      next_operand = data_in;
    if (req_wr && armed && busy)
      next_req = 1'b1;
    if (operand_transfer_request && !operand_transfer_ack)
      next_req = 1'b0;
    if (done_wr && done_finish && busy && !wr_op) begin
      next_busy  = 1'b0;
      next_armed = 1'b0;
      next_req   = 1'b0;
      if (done_except)
        next_error = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy                     <= 1'b0;
      error                    <= 1'b0;
      operand_transfer_request <= 1'b0;
      armed                    <= 1'b0;
      opcode                   <= 16'h0000;
      operand                  <= 16'h0000;
    end else begin
      busy                     <= next_busy;
      error                    <= next_error;
      operand_transfer_request <= next_req;
      armed                    <= next_armed;
      opcode                   <= next_opcode;
      operand                  <= next_operand;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_go;
  logic [coproc_pkg::EV_WIDTH-1:0] events, next_events, ev_en, next_ev_en, ev_set;
  logic [15:0] wr_reg, next_wr_reg;

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_go   = aw_held && w_held && !bvalid;
  assign done_wr = wr_go && (aw_addr == coproc_pkg::REG_DONE);
  assign req_wr  = wr_go && (aw_addr == coproc_pkg::REG_REQ);
  assign done_finish = w_data[coproc_pkg::DONE_FINISH];
  assign done_except = w_data[coproc_pkg::DONE_EXCEPT];
  assign read_word   = wr_reg;

  always_comb begin
    ev_set = '0;
    ev_set[coproc_pkg::EV_OPCODE]  = wr_op;
    ev_set[coproc_pkg::EV_OPERAND] = wr_operand || wr_ctl;
    ev_set[coproc_pkg::EV_READ]    = rd_any;
    ev_set[coproc_pkg::EV_ERROR]   = next_error && !error;
  end

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    next_rvalid  = rvalid && !rready;
    next_rresp   = rresp;
    next_rdata   = rdata;
    next_events  = events;
    next_ev_en   = ev_en;
    next_wr_reg  = wr_reg;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = coproc_pkg::RESP_OKAY;
      case (aw_addr)
        coproc_pkg::REG_CONTROL:  ;
        coproc_pkg::REG_DONE:     ;
        coproc_pkg::REG_REQ:      ;
        coproc_pkg::REG_EV_CLEAR: next_events = events & ~w_data[coproc_pkg::EV_WIDTH-1:0];
        coproc_pkg::REG_EV_EN:    next_ev_en  = w_data[coproc_pkg::EV_WIDTH-1:0];
        coproc_pkg::REG_WDATA:    next_wr_reg = w_data[15:0];
        default:                  next_bresp  = coproc_pkg::RESP_SLVERR;
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    next_events = next_events | ev_set;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = coproc_pkg::RESP_OKAY;
      case (araddr)
        coproc_pkg::REG_CONTROL: next_rdata = {31'd0, strap};
        coproc_pkg::REG_STATUS:  next_rdata = {27'd0, armed, strap, operand_transfer_request, error, busy};
        coproc_pkg::REG_EVENTS:  next_rdata = {28'd0, events};
        coproc_pkg::REG_EV_EN:   next_rdata = {28'd0, ev_en};
        coproc_pkg::REG_OPCODE:  next_rdata = {16'd0, opcode};
        coproc_pkg::REG_OPERAND: next_rdata = {16'd0, operand};
        coproc_pkg::REG_WDATA:   next_rdata = {16'd0, wr_reg};
        coproc_pkg::REG_EV_CLEAR,
        coproc_pkg::REG_DONE,
        coproc_pkg::REG_REQ:     next_rdata = 32'h0000_0000;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = coproc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
      rvalid  <= 1'b0;
      rresp   <= 2'b00;
      rdata   <= 32'h0000_0000;
      events  <= '0;
      ev_en   <= '0;
      wr_reg  <= 16'h0000;
      irq     <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      events  <= next_events;
      ev_en   <= next_ev_en;
      wr_reg  <= next_wr_reg;
      irq     <= |(next_events & next_ev_en);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_busy_on_opcode: assert property (@(posedge clock) disable iff (!rstn)
    wr_op |=> busy) else $error("busy not raised by opcode write");
  a_error_before_idle: assert property (@(posedge clock) disable iff (!rstn)
    $fell(busy) && done_except && $past(done_wr) |-> error) else $error("error late");
  a_req_until_ack: assert property (@(posedge clock) disable iff (!rstn)
    operand_transfer_request && operand_transfer_ack && busy && !(done_wr && done_finish) |=> operand_transfer_request)
    else $error("request dropped without ack");
  a_no_req_idle: assert property (@(posedge clock) disable iff (!rstn)
    !busy |-> !operand_transfer_request) else $error("request while idle");
  a_reserved_ignored: assert property (@(posedge clock) disable iff (!rstn)
    command_bit_zero && command_bit_one |=> !data_oe) else $error("reserved port answered");
  a_read_zero_wait: assert property (@(posedge clock) disable iff (!rstn)
    rd_any |=> data_oe && data_out == $past(read_word)) else $error("read not served");
  a_div_three: assert property (@(posedge clock) disable iff (!rstn)
    !strap && core_tick |=> !core_tick ##1 !core_tick ##1 core_tick) else $error("divide ratio");
  a_ext_clock: assert property (@(posedge clock) disable iff (!rstn)
    strap |-> core_tick == ext_clock_tick) else $error("external clock not used");
  a_select_only: assert property (@(posedge clock) disable iff (!rstn)
    !select_high_active && coproc_write_strobe |=> $stable(opcode)) else $error("unselected write");

  c_instr_done: cover property (@(posedge clock) disable iff (!rstn) $fell(busy));
  c_error_end: cover property (@(posedge clock) disable iff (!rstn) $rose(error));
  c_req_ack: cover property (@(posedge clock) disable iff (!rstn) $fell(operand_transfer_request) && busy);
  c_irq: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
endmodule // coproc_port

// [tb/host_glue.sv]
/*
  Host side glue model: turns host I/O cycles into coprocessor select,
  command and strobe pins, and gates the local data buffer on reads.
  Assumes the bench drives the I/O cycle signals just after a rising edge.
*/
`timescale 1ns/1ps
module host_glue (
  // Clock
  input  wire logic        clock,
  // Host I/O cycle
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [15:0] io_data,
  // Coprocessor pins
  output logic             select_low_active,
  output logic             select_high_active,
  output logic             command_bit_zero,
  output logic             command_bit_one,
  output logic             coproc_read_strobe,
  output logic             coproc_write_strobe,
  output logic [15:0]      data_in,
  output logic             local_buf_en
);
  logic        hit;
  logic [15:0] last;
  // Whole group 00f8..00fe selects; the device itself must ignore 00fe
  assign hit                 = (io_addr[15:3] == 13'h001f);
  assign select_high_active  = hit;
  assign select_low_active   = !hit;
  assign command_bit_zero    = io_addr[1];
  assign command_bit_one     = io_addr[2];
  assign coproc_read_strobe  = io_rd;
  assign coproc_write_strobe = io_wr;
  assign local_buf_en        = !(io_rd && hit);
  // Released lines show the inverse of the last value, never a stale copy
  assign data_in             = io_wr ? io_data : ~last;
  always_ff @(posedge clock) begin
    last <= data_in;
  end
endmodule // host_glue

// [tb/tb_numeric_coprocessor_port.sv]
/*
  Self-checking bench for the coprocessor port: port decode, busy, error,
  transfer request, clock modes, registers and interrupt over AXI4-Lite.
  Assumes the host glue model stands in front of the host pins.
*/
`timescale 1ns/1ps
module tb_numeric_coprocessor_port;
  logic        clock, rstn, ext_clock_tick, clock_mode_strap, operand_transfer_ack;
  logic [15:0] io_addr, io_data, data_in, data_out;
  logic        io_rd, io_wr, sl, sh, c0, c1, rs, ws, local_buf_en;
  logic        data_oe, busy, error, operand_transfer_request, core_tick, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          failures, total_checks;

  host_glue glue_u (.clock(clock), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_data(io_data),
    .select_low_active(sl), .select_high_active(sh), .command_bit_zero(c0), .command_bit_one(c1),
    .coproc_read_strobe(rs), .coproc_write_strobe(ws), .data_in(data_in), .local_buf_en(local_buf_en));
  coproc_port dut_u (.clock(clock), .rstn(rstn), .ext_clock_tick(ext_clock_tick),
    .clock_mode_strap(clock_mode_strap), .select_low_active(sl), .select_high_active(sh),
    .command_bit_zero(c0), .command_bit_one(c1), .coproc_read_strobe(rs), .coproc_write_strobe(ws),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .busy(busy), .error(error),
    .operand_transfer_request(operand_transfer_request), .operand_transfer_ack(operand_transfer_ack),
    .core_tick(core_tick), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));

  // ---------------------------------------------------------------
  // Support tasks
  // ---------------------------------------------------------------
  task automatic check_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Callers enter just after a rising edge; readies are sampled before that edge's updates land
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (n < 50 && bvalid !== 1'b1) begin
      @(posedge clock);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 50) failures++;
    @(posedge clock);
  endtask
  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (n < 50 && rvalid !== 1'b1) begin
      @(posedge clock);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 50) failures++;
    @(posedge clock);
  endtask
  // One zero-wait I/O cycle, then a quiet cycle; only escape-generated cycles, never explicit program access
  task automatic port_io(input logic [15:0] a, input logic wr, input logic [15:0] d);
    int n;
    n = 0;
    // A new instruction waits for the engine to go idle
    while (a == 16'h00f8 && busy !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) failures++;
    io_addr <= a; io_data <= d; io_wr <= wr; io_rd <= !wr;
    @(posedge clock);
    io_wr <= 1'b0; io_rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic do_reset(input logic strap);
    rstn <= 1'b0; clock_mode_strap <= strap;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_decode();
    axi_read(coproc_pkg::REG_STATUS);
    check_word(rd, 32'h0, "status after reset");
    check_word({30'h0, rsp}, {30'h0, coproc_pkg::RESP_OKAY}, "read okay");
    port_io(16'h00f8, 1'b1, 16'h1d2e);
    check_bit(busy, 1'b1, "busy after opcode");
    axi_write(coproc_pkg::REG_EV_CLEAR, 32'hf);
    port_io(16'h00fe, 1'b1, 16'h5555);
    port_io(16'h00f0, 1'b1, 16'h6666);
    axi_read(coproc_pkg::REG_EVENTS);
    check_word(rd, 32'h0, "reserved or foreign port");
    port_io(16'h00fa, 1'b1, 16'h4321);
    port_io(16'h00fc, 1'b1, 16'h0707);
    axi_read(coproc_pkg::REG_OPCODE);
    check_word(rd, 32'h1d2e, "opcode word");
    axi_read(coproc_pkg::REG_OPERAND);
    check_word(rd, 32'h4321, "operand word, control write kept apart");
    axi_write(coproc_pkg::REG_WDATA, 32'h9abc);
    check_word({30'h0, rsp}, {30'h0, coproc_pkg::RESP_OKAY}, "write okay");
    axi_write(8'h40, 32'h0);
    check_word({30'h0, rsp}, {30'h0, coproc_pkg::RESP_SLVERR}, "unmapped write");
    io_addr <= 16'h00fa; io_rd <= 1'b1;
    @(posedge clock);
    io_rd <= 1'b0;
    @(posedge clock);
    check_bit(data_oe, 1'b1, "read drives data");
    check_word({16'h0, data_out}, 32'h9abc, "read word");
    axi_read(8'h40);
    check_word({30'h0, rsp}, {30'h0, coproc_pkg::RESP_SLVERR}, "unmapped");
    $display("test decode done");
  endtask
  task automatic t_request();
    axi_write(coproc_pkg::REG_REQ, 32'h1);
    repeat (4) @(posedge clock);
    check_bit(operand_transfer_request, 1'b1, "request held");
    operand_transfer_ack <= 1'b0;
    @(posedge clock);
    operand_transfer_ack <= 1'b1;
    @(posedge clock);
    check_bit(operand_transfer_request, 1'b0, "request dropped by ack");
    axi_write(coproc_pkg::REG_DONE, 32'h1);
    check_bit(busy, 1'b0, "busy released");
    check_bit(error, 1'b0, "no exception");
    axi_write(coproc_pkg::REG_REQ, 32'h1);
    @(posedge clock);
    check_bit(operand_transfer_request, 1'b0, "no request after busy");
    $display("test request done");
  endtask
  task automatic t_error();
    port_io(16'h00f8, 1'b1, 16'h0042);
    axi_write(coproc_pkg::REG_EV_CLEAR, 32'hf);
    axi_write(coproc_pkg::REG_EV_EN, 32'h1 << coproc_pkg::EV_ERROR);
    check_bit(irq, 1'b0, "irq masked");
    axi_write(coproc_pkg::REG_DONE, 32'h3);
    check_bit(error, 1'b1, "error on exception");
    check_bit(busy, 1'b0, "busy ends");
    check_bit(irq, 1'b1, "irq on error");
    axi_write(coproc_pkg::REG_EV_CLEAR, 32'h1 << coproc_pkg::EV_ERROR);
    @(posedge clock);
    check_bit(irq, 1'b0, "irq cleared");
    $display("test error done");
  endtask
  task automatic t_clock(input logic strap);
    int n;
    n = 0;
    do_reset(strap);
    for (int i = 0; i < 60; i++) begin
      @(posedge clock);
      if (core_tick === 1'b1) n++;
      ext_clock_tick <= strap && (i % 4 == 0) && (i < 40);
    end
    check_word(n, strap ? 32'd10 : 32'd20, "core ticks");
    axi_read(coproc_pkg::REG_CONTROL);
    check_word(rd, {31'h0, strap}, "strap latched");
    $display("test clock mode done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
  initial begin
    failures = 0; total_checks = 0; rstn = 1'b0; ext_clock_tick = 1'b0; clock_mode_strap = 1'b0;
    operand_transfer_ack = 1'b1; io_addr = 16'h0; io_data = 16'h0; io_rd = 1'b0; io_wr = 1'b0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'hf; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    do_reset(1'b0);
    t_decode();
    t_request();
    t_error();
    t_clock(1'b0);
    t_clock(1'b1);
    report_and_stop();
  end
endmodule // tb_numeric_coprocessor_port
